/* hw/parallel_host_bus_interface.sv */
// Parallel host port: strobes, register select, data bus, interrupt, trigger.
`timescale 1ns/100ps
module parallel_host_bus_interface #(
   parameter int INIT_CYCLES = host_port_pkg::INIT_CYCLES
) (
   // Clock and reset
   input wire logic sys_clk_i,
   input wire logic sys_rst_i,
   input wire logic hw_reset_n_i,
   // Host bus pins
   input wire logic chip_sel_n_i,
   input wire logic wr_strobe_n_i,
   input wire logic rd_strobe_n_i,
   input wire logic [7:0] reg_select_lines_i,
   input wire logic [7:0] host_data_bus_i,
   output logic [7:0] host_data_bus_o,
   output logic host_data_bus_oe_o,
   // Interrupt pin, open drain
   output logic irq_n_o,
   output logic irq_n_oe_o,
   // Frame trigger pin
   input wire logic frame_start_input_i,
   // Oscillator and PLL status
   input wire logic osc_running_i,
   input wire logic pll_locked_i,
   // Core side
   output logic ctrl_ready_o,
   output logic reg_wr_o,
   output logic reg_rd_o,
   output logic [7:0] reg_addr_o,
   output logic [7:0] reg_wdata_o,
   input wire logic [7:0] reg_rdata_i,
   output logic frame_start_o,
   input wire logic irq_cause_i,
   input wire logic irq_mask_i
);
   localparam int CNT_W = $clog2(INIT_CYCLES + 1);

   // ----------------------------------------------------------------
   // Elaboration checks
   // ----------------------------------------------------------------
   if (INIT_CYCLES < 1) begin : g_chk
      $error("INIT_CYCLES must be at least one");
   end

   // ----------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------
   logic rst_lvl;
   logic cs_lvl;
   logic wr_lvl;
   logic wr_rise;
   logic wr_fall;
   logic rd_lvl;
   logic rd_fall;
   logic frame_start_input_rise;

   // The reset pin is synchronised too; its weak pull-up sits in the pad, so an open pin reads high.
   pin_sync #(
      .RESET_VAL(1'b1)
   ) u_rst (
      .sys_clk_i(sys_clk_i),
      .sys_rst_i(sys_rst_i),
      .pin_i(hw_reset_n_i),
      .level_o(rst_lvl),
      .rise_o(),
      .fall_o()
   );

   // Chip select only needs its level; the edges come from the strobes.
   pin_sync #(
      .RESET_VAL(1'b1)
   ) u_cs (
      .sys_clk_i(sys_clk_i),
      .sys_rst_i(sys_rst_i),
      .pin_i(chip_sel_n_i),
      .level_o(cs_lvl),
      .rise_o(),
      .fall_o()
   );

   // Write strobe: the fall opens a write and the rise commits it.
   pin_sync #(
      .RESET_VAL(1'b1)
   ) u_wr (
      .sys_clk_i(sys_clk_i),
      .sys_rst_i(sys_rst_i),
      .pin_i(wr_strobe_n_i),
      .level_o(wr_lvl),
      .rise_o(wr_rise),
      .fall_o(wr_fall)
   );

   // Read strobe: the fall starts a read and the level gates the drivers.
   pin_sync #(
      .RESET_VAL(1'b1)
   ) u_rd (
      .sys_clk_i(sys_clk_i),
      .sys_rst_i(sys_rst_i),
      .pin_i(rd_strobe_n_i),
      .level_o(rd_lvl),
      .rise_o(),
      .fall_o(rd_fall)
   );

   // The trigger idles low, so its synchroniser resets low to avoid a false edge.
   pin_sync #(
      .RESET_VAL(1'b0)
   ) u_frame_start_input (
      .sys_clk_i(sys_clk_i),
      .sys_rst_i(sys_rst_i),
      .pin_i(frame_start_input_i),
      .level_o(),
      .rise_o(frame_start_input_rise),
      .fall_o()
   );

   // Select lines pass two stages; the host holds them for the whole strobe.
   // Data pass five stages, so when the synchronised write rise arrives the
   // last stage holds the byte that stood on the pins just before the rise.
   // A host may move its data at that edge, so any later sample is unsafe.
   logic [7:0] sel_s1_q;
   logic [7:0] sel_s2_q;
   logic [7:0] dat_s1_q;
   logic [7:0] dat_s2_q;
   logic [7:0] dat_s3_q;
   logic [7:0] dat_s4_q;
   logic [7:0] dat_s5_q;

   // Sample pipeline for the select and data pins.
   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         sel_s1_q <= 8'h00;
         sel_s2_q <= 8'h00;
         dat_s1_q <= 8'h00;
         dat_s2_q <= 8'h00;
         dat_s3_q <= 8'h00;
         dat_s4_q <= 8'h00;
         dat_s5_q <= 8'h00;
      end else begin
         sel_s1_q <= reg_select_lines_i;
         sel_s2_q <= sel_s1_q;
         dat_s1_q <= host_data_bus_i;
         dat_s2_q <= dat_s1_q;
         dat_s3_q <= dat_s2_q;
         dat_s4_q <= dat_s3_q;
         dat_s5_q <= dat_s4_q;
      end
   end

   // ----------------------------------------------------------------
   // Internal reset and startup
   // ----------------------------------------------------------------
   logic core_rst;
   assign core_rst = sys_rst_i | ~rst_lvl;

   logic [CNT_W-1:0] init_cnt_q;
   logic [CNT_W-1:0] init_cnt_d;
   logic ready_q;
   logic ready_d;

   // The wait count only runs once oscillator and PLL report good, so a
   // slow lock can never be mistaken for ready. Nothing here looks at the
   // serial channel's enable, so a disabled channel never stops the clock.
   always_comb begin
      init_cnt_d = init_cnt_q;
      ready_d = ready_q;
      if (!(osc_running_i && pll_locked_i)) begin
         init_cnt_d = '0;
         ready_d = 1'b0;
      end else if (init_cnt_q == CNT_W'(INIT_CYCLES)) begin
         ready_d = 1'b1;
      end else begin
         init_cnt_d = init_cnt_q + CNT_W'(1);
      end
   end

   // Startup state; pin reset restarts the wait as at power-on.
   always_ff @(posedge sys_clk_i) begin
      if (core_rst) begin
         init_cnt_q <= '0;
         ready_q <= 1'b0;
      end else begin
         init_cnt_q <= init_cnt_d;
         ready_q <= ready_d;
      end
   end

   // ----------------------------------------------------------------
   // Register transfers
   // ----------------------------------------------------------------
   logic [7:0] addr_q;
   logic [7:0] addr_d;
   logic [7:0] wdata_q;
   logic [7:0] wdata_d;
   logic wr_q;
   logic wr_d;
   logic rd_q;
   logic rd_d;
   logic wr_open_q;
   logic wr_open_d;
   logic [7:0] rbuf_q;
   logic [7:0] rbuf_d;
   logic oe_q;
   logic oe_d;
   logic rd_lat_q;
   logic rd_lat_d;

   // A write opens at the strobe fall with chip select low and closes at the
   // rising edge; chip select may rise with the strobe, so the open flag,
   // not the live chip select, qualifies the rising edge.
   always_comb begin
      addr_d = addr_q;
      wdata_d = wdata_q;
      wr_d = 1'b0;
      rd_d = 1'b0;
      wr_open_d = wr_open_q;
      rbuf_d = rbuf_q;
      rd_lat_d = rd_q;
      if (!cs_lvl && (wr_fall || rd_fall)) begin
         addr_d = sel_s2_q;
      end
      if (!cs_lvl && wr_fall) begin
         wr_open_d = 1'b1;
      end
      if (wr_rise && wr_open_q) begin
         wdata_d = dat_s5_q;
         wr_d = 1'b1;
         wr_open_d = 1'b0;
      end else if (cs_lvl && wr_lvl) begin
         wr_open_d = 1'b0;
      end
      if (!cs_lvl && rd_fall) begin
         rd_d = 1'b1;
      end
      if (rd_lat_q) begin
         rbuf_d = reg_rdata_i;
      end
      oe_d = ~cs_lvl & ~rd_lvl;
   end

   // Transfer state; pin reset clears any half-done access.
   always_ff @(posedge sys_clk_i) begin
      if (core_rst) begin
         addr_q <= host_port_pkg::REG_RESET_VAL;
         wdata_q <= host_port_pkg::REG_RESET_VAL;
         wr_q <= 1'b0;
         rd_q <= 1'b0;
         wr_open_q <= 1'b0;
         rbuf_q <= host_port_pkg::REG_RESET_VAL;
         oe_q <= 1'b0;
         rd_lat_q <= 1'b0;
      end else begin
         addr_q <= addr_d;
         wdata_q <= wdata_d;
         wr_q <= wr_d;
         rd_q <= rd_d;
         wr_open_q <= wr_open_d;
         rbuf_q <= rbuf_d;
         oe_q <= oe_d;
         rd_lat_q <= rd_lat_d;
      end
   end

   // ----------------------------------------------------------------
   // Interrupt and trigger
   // ----------------------------------------------------------------
   logic irq_oe_q;
   logic irq_oe_d;
   logic frame_start_input_q;
   logic frame_start_input_d;

   // The line is only ever pulled low; the pull-up supplies the high level.
   always_comb begin
      irq_oe_d = irq_cause_i & ~irq_mask_i;
      frame_start_input_d = frame_start_input_rise;
   end

   // Interrupt and trigger registers; the line is released during reset.
   always_ff @(posedge sys_clk_i) begin
      if (core_rst) begin
         irq_oe_q <= 1'b0;
         frame_start_input_q <= 1'b0;
      end else begin
         irq_oe_q <= irq_oe_d;
         frame_start_input_q <= frame_start_input_d;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign host_data_bus_o = rbuf_q;
   assign host_data_bus_oe_o = oe_q;
   assign irq_n_o = 1'b0;
   assign irq_n_oe_o = irq_oe_q;
   assign ctrl_ready_o = ready_q;
   assign reg_wr_o = wr_q;
   assign reg_rd_o = rd_q;
   assign reg_addr_o = addr_q;
   assign reg_wdata_o = wdata_q;
   assign frame_start_o = frame_start_input_q;
endmodule // parallel_host_bus_interface

/* hw/host_port_pkg.sv */
// Package with constants for the parallel host bus interface.
//
// Function
// - Write captures the data bus into the selected register on write strobe rise.
// - Read begins at read strobe fall; selected register drives data lines.
// - Data lines driven only while read strobe and chip select are low.
// - Chip select high releases data lines and ignores strobes.
// - Interrupt output is active low open drain, never driven high.
// - Frame trigger input event starts a new frame.
// - Hardware reset low returns the device to power-on state; weak pull-up.
// - All timing derives from 12.0 MHz oscillator and 156 MHz PLL.
// - Ready is withheld until oscillator started and PLL locked.
// - Oscillator keeps running while the serial channel is disabled.
// - Device is always serial bus master; host handshakes by interrupt or poll.
// - Select lines registered when chip select low and either strobe falls.
// - Data bus is 8 bits bidirectional, lowest line is the LSB.
package host_port_pkg;

   // ----------------------------------------------------------------
   // Bus widths
   // ----------------------------------------------------------------
   localparam int DATA_W = 8;
   localparam int SEL_W = 8;

   // ----------------------------------------------------------------
   // Clock and timing
   // ----------------------------------------------------------------
   localparam int SYS_CLK_KHZ = 25000;
   localparam int OSC_KHZ = 12000;
   localparam int PLL_KHZ = 156000;
   // Startup wait after oscillator and PLL report good, in microseconds.
   localparam int INIT_TIME_US = 1000;
   localparam int INIT_CYCLES = (INIT_TIME_US * SYS_CLK_KHZ) / 1000;

   // ----------------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------------
   localparam logic [7:0] REG_RESET_VAL = 8'h00;

endpackage

/* hw/pin_sync.sv */
// Three-stage synchroniser for one asynchronous pin.
`timescale 1ns/100ps
module pin_sync #(
   parameter logic RESET_VAL = 1'b1
) (
   // Clock and reset
   input wire logic sys_clk_i,
   input wire logic sys_rst_i,
   // Pin and result
   input wire logic pin_i,
   output logic level_o,
   output logic rise_o,
   output logic fall_o
);
   logic [2:0] stage_q;
   logic [2:0] stage_d;
   logic level_q;
   logic level_d;
   logic rise_q;
   logic rise_d;
   logic fall_q;
   logic fall_d;

   // A change is accepted once the second and third stages agree, so the
   // first stage is never examined directly.
   always_comb begin
      stage_d = {stage_q[1:0], pin_i};
      level_d = level_q;
      if (stage_q[1] == stage_q[2]) begin
         level_d = stage_q[2];
      end
      rise_d = level_d & ~level_q;
      fall_d = ~level_d & level_q;
   end

   // Registers only; the reset value matches the pin's idle level.
   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         stage_q <= {3{RESET_VAL}};
         level_q <= RESET_VAL;
         rise_q <= 1'b0;
         fall_q <= 1'b0;
      end else begin
         stage_q <= stage_d;
         level_q <= level_d;
         rise_q <= rise_d;
         fall_q <= fall_d;
      end
   end

   assign level_o = level_q;
   assign rise_o = rise_q;
   assign fall_o = fall_q;
endmodule // pin_sync

/* tb/host_port_assertions.sv */
// Concurrent checks on the parallel host port pins and core strobes.
`timescale 1ns/100ps
module host_port_assertions (
   // Clock and reset
   input wire logic sys_clk_i,
   input wire logic sys_rst_i,
   input wire logic hw_reset_n_i,
   // Observed ports
   input wire logic chip_sel_n_i,
   input wire logic wr_strobe_n_i,
   input wire logic rd_strobe_n_i,
   input wire logic host_data_bus_oe_o,
   input wire logic irq_n_o,
   input wire logic irq_n_oe_o,
   input wire logic irq_cause_i,
   input wire logic irq_mask_i,
   input wire logic pll_locked_i,
   input wire logic ctrl_ready_o,
   input wire logic reg_wr_o,
   input wire logic reg_rd_o,
   input wire logic frame_start_input_i,
   input wire logic frame_start_o
);
   default clocking cb @(posedge sys_clk_i);
   endclocking
   // The reset pin also holds the core, so the checks rest while it is low.
   default disable iff (sys_rst_i || !hw_reset_n_i);
   // Six quiet cycles cover the pin synchronisers, so any drive after that is a real fault.
   a_oe_needs_sel: assert property (chip_sel_n_i [*6] |-> !host_data_bus_oe_o)
      else $error("data bus driven while chip select high");
   a_oe_needs_rd: assert property (rd_strobe_n_i [*6] |-> !host_data_bus_oe_o)
      else $error("data bus driven while read strobe high");
   a_irq_low_only: assert property (!irq_n_o)
      else $error("interrupt pin driven high");
   a_irq_set: assert property ((irq_cause_i && !irq_mask_i) [*3] |-> irq_n_oe_o)
      else $error("interrupt not asserted for unmasked cause");
   a_irq_clear: assert property ((!irq_cause_i || irq_mask_i) [*3] |-> !irq_n_oe_o)
      else $error("interrupt held without unmasked cause");
   a_wr_taken: assert property ($rose(wr_strobe_n_i) && $past(!chip_sel_n_i) |-> ##[2:8] reg_wr_o)
      else $error("selected write not taken");
   a_rd_taken: assert property ($fell(rd_strobe_n_i) && !chip_sel_n_i |-> ##[2:8] reg_rd_o)
      else $error("selected read not started");
   a_wr_once: assert property (reg_wr_o |=> !reg_wr_o)
      else $error("write pulse longer than one cycle");
   a_frame_start: assert property ($rose(frame_start_input_i) |-> ##[2:8] frame_start_o)
      else $error("trigger did not start a frame");
   a_ready_gate: assert property (!pll_locked_i [*2] |-> !ctrl_ready_o)
      else $error("ready without locked clock");
   // Main scenarios reached.
   c_write: cover property (reg_wr_o);
   c_read: cover property (reg_rd_o);
   c_irq: cover property (irq_n_oe_o);
   c_frame: cover property (frame_start_o);
endmodule // host_port_assertions

bind parallel_host_bus_interface host_port_assertions u_chk (.sys_clk_i, .sys_rst_i, .chip_sel_n_i,
   .wr_strobe_n_i, .rd_strobe_n_i, .host_data_bus_oe_o, .irq_n_o, .irq_n_oe_o, .irq_cause_i, .irq_mask_i,
   .pll_locked_i, .ctrl_ready_o, .reg_wr_o, .reg_rd_o, .frame_start_input_i, .frame_start_o, .hw_reset_n_i);

/* tb/host_bus_model.sv */
// Host processor model driving the parallel bus pins.
`timescale 1ns/100ps
module host_bus_model (
   // Clock
   input wire logic sys_clk_i,
   // Pins toward the device
   output logic chip_sel_n_o,
   output logic wr_strobe_n_o,
   output logic rd_strobe_n_o,
   output logic [7:0] reg_select_lines_o,
   output logic [7:0] bus_o,
   // Device drive of the data pins
   input wire logic [7:0] dev_data_i,
   input wire logic dev_oe_i
);
   logic drv;
   logic [7:0] hval;
   logic [7:0] last_q = 8'h00;
   // Idle pins at time zero.
   initial begin
      chip_sel_n_o = 1'b1;
      wr_strobe_n_o = 1'b1;
      rd_strobe_n_o = 1'b1;
      reg_select_lines_o = 8'h00;
      drv = 1'b0;
      hval = 8'h00;
   end
   // No pull on the data pins, so an undriven bus flips each cycle and stale data never passes.
   assign bus_o = dev_oe_i ? dev_data_i : (drv ? hval : ~last_q);
   always @(posedge sys_clk_i) last_q <= bus_o;
   // Mode 0 toggles chip select with the strobe, 1 holds it low, 2 keeps it high.
   // The byte is inverted as the strobe rises, so only a capture at the edge keeps it.
   task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] m);
      @(negedge sys_clk_i);
      reg_select_lines_o = a;
      hval = d;
      drv = 1'b1;
      chip_sel_n_o = (m != 2'd1);
      repeat (2) @(negedge sys_clk_i);
      chip_sel_n_o = (m == 2'd2);
      wr_strobe_n_o = 1'b0;
      repeat (6) @(negedge sys_clk_i);
      wr_strobe_n_o = 1'b1;
      chip_sel_n_o = (m != 2'd1);
      hval = ~d;
   endtask
   // Read with chip select moving together with the strobe, legal also during startup.
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(negedge sys_clk_i);
      reg_select_lines_o = a;
      chip_sel_n_o = 1'b0;
      rd_strobe_n_o = 1'b0;
      repeat (10) @(negedge sys_clk_i);
      d = bus_o;
      chip_sel_n_o = 1'b1;
      rd_strobe_n_o = 1'b1;
      repeat (5) @(negedge sys_clk_i);
   endtask
   // Data drive and chip select are released here, then the bus rests.
   task automatic rel();
      @(negedge sys_clk_i);
      drv = 1'b0;
      chip_sel_n_o = 1'b1;
      repeat (4) @(negedge sys_clk_i);
   endtask
endmodule // host_bus_model

/* tb/parallel_host_bus_interface_tb_top.sv */
// Self-checking bench for the parallel host bus interface.
`timescale 1ns/100ps
module parallel_host_bus_interface_tb_top;
   logic sys_clk_i = 1'b0;
   logic sys_rst_i = 1'b1;
   logic hw_reset_n_i = 1'b1;
   logic osc_running_i = 1'b0, pll_locked_i = 1'b0, frame_start_input_i = 1'b0;
   logic irq_cause_i = 1'b0, irq_mask_i = 1'b0;
   logic [7:0] reg_rdata_i = 8'h00;
   logic chip_sel_n_i, wr_strobe_n_i, rd_strobe_n_i, host_data_bus_oe_o, irq_n_o, irq_n_oe_o;
   logic ctrl_ready_o, reg_wr_o, reg_rd_o, frame_start_o;
   logic [7:0] reg_select_lines_i, host_data_bus_i, host_data_bus_o, reg_addr_o, reg_wdata_o;
   int fails = 0, total_checks = 0;
   // Short startup count keeps the run brief.
   host_bus_model host (.sys_clk_i, .chip_sel_n_o(chip_sel_n_i), .wr_strobe_n_o(wr_strobe_n_i),
      .rd_strobe_n_o(rd_strobe_n_i), .reg_select_lines_o(reg_select_lines_i), .bus_o(host_data_bus_i),
      .dev_data_i(host_data_bus_o), .dev_oe_i(host_data_bus_oe_o));
   parallel_host_bus_interface #(.INIT_CYCLES(5)) DUT (.sys_clk_i, .sys_rst_i, .hw_reset_n_i,
      .chip_sel_n_i, .wr_strobe_n_i, .rd_strobe_n_i, .reg_select_lines_i, .host_data_bus_i,
      .host_data_bus_o, .host_data_bus_oe_o, .irq_n_o, .irq_n_oe_o, .frame_start_input_i, .osc_running_i,
      .pll_locked_i, .ctrl_ready_o, .reg_wr_o, .reg_rd_o, .reg_addr_o, .reg_wdata_o, .reg_rdata_i,
      .frame_start_o, .irq_cause_i, .irq_mask_i);
   // Clock of 40 ns period.
   initial forever #20 sys_clk_i = ~sys_clk_i;
   task automatic summarize();
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      total_checks++;
      if (got !== exp) begin
         fails++;
         $display("unexpected at %0t: got %h exp %h", $time, got, exp);
      end
   endtask
   // Bounded watch: 0 write pulse, 2 frame pulse, else ready level.
   task automatic wait_pulse(input int s, input bit must);
      bit seen;
      seen = 1'b0;
      for (int i = 0; i < 40 && !(seen && must); i++) begin
         @(negedge sys_clk_i);
         seen |= (s == 0) ? reg_wr_o === 1'b1 : (s == 2) ? frame_start_o === 1'b1 : ctrl_ready_o === 1'b1;
      end
      chk(8'(seen), 8'(must));
      if (must && !seen)
         summarize();
   endtask
   task automatic t_ready();
      logic [7:0] d;
      repeat (20) @(negedge sys_clk_i);
      host.rd(8'h00, d);
      chk(8'(ctrl_ready_o), 8'h00);
      osc_running_i = 1'b1;
      pll_locked_i = 1'b1;
      repeat (3) @(negedge sys_clk_i);
      chk(8'(ctrl_ready_o), 8'h00);
      wait_pulse(3, 1'b1);
      pll_locked_i = 1'b0;
      repeat (3) @(negedge sys_clk_i);
      chk(8'(ctrl_ready_o), 8'h00);
      pll_locked_i = 1'b1;
      wait_pulse(3, 1'b1);
      $display("test ready done");
   endtask
   task automatic t_write();
      host.wr(8'h01, 8'h80, 2'd1);
      wait_pulse(0, 1'b1);
      chk(reg_addr_o, 8'h01);
      chk(reg_wdata_o, 8'h80);
      host.rel();
      host.wr(8'h80, 8'h01, 2'd0);
      wait_pulse(0, 1'b1);
      chk(reg_addr_o, 8'h80);
      chk(reg_wdata_o, 8'h01);
      host.rel();
      $display("test write done");
   endtask
   task automatic t_read();
      logic [7:0] d;
      reg_rdata_i = 8'h3C;
      host.rd(8'hA5, d);
      chk(d, 8'h3C);
      chk(reg_addr_o, 8'hA5);
      chk(8'(host_data_bus_oe_o), 8'h00);
      $display("test read done");
   endtask
   task automatic t_ce_high();
      host.wr(8'h33, 8'h44, 2'd2);
      wait_pulse(0, 1'b0);
      chk(reg_addr_o, 8'hA5);
      host.rel();
      $display("test deselect done");
   endtask
   task automatic t_irq();
      irq_cause_i = 1'b1;
      repeat (4) @(negedge sys_clk_i);
      chk(8'(irq_n_oe_o), 8'h01);
      chk(8'(irq_n_o), 8'h00);
      irq_mask_i = 1'b1;
      repeat (4) @(negedge sys_clk_i);
      chk(8'(irq_n_oe_o), 8'h00);
      irq_mask_i = 1'b0;
      irq_cause_i = 1'b0;
      repeat (4) @(negedge sys_clk_i);
      chk(8'(irq_n_oe_o), 8'h00);
      $display("test interrupt done");
   endtask
   task automatic t_frame_reset();
      frame_start_input_i = 1'b1;
      wait_pulse(2, 1'b1);
      frame_start_input_i = 1'b0;
      hw_reset_n_i = 1'b0;
      irq_cause_i = 1'b1;
      repeat (8) @(negedge sys_clk_i);
      chk(8'(ctrl_ready_o), 8'h00);
      chk(8'(irq_n_oe_o), 8'h00);
      hw_reset_n_i = 1'b1;
      irq_cause_i = 1'b0;
      wait_pulse(3, 1'b1);
      $display("test frame and pin reset done");
   endtask
   // Main sequence: reset held three cycles, then every scenario in turn.
   initial begin
      repeat (3) @(negedge sys_clk_i);
      sys_rst_i = 1'b0;
      t_ready();
      t_write();
      t_read();
      t_ce_high();
      t_irq();
      t_frame_reset();
      summarize();
   end
endmodule // parallel_host_bus_interface_tb_top
